// ===== verilog/fhq_pkg.sv
// shared constants and carrier types for the host port / dma qualify block
// assumes one 100 MHz clock and an ahb-lite master for the register bus
package fhq_pkg;

  // host operating modes, selected by software through the config register
  typedef enum logic [1:0] {
    FHQ_MODE_BASE    = 2'b00,
    FHQ_MODE_SPECIAL = 2'b01,
    FHQ_MODE_LEGACY  = 2'b10
  } fhq_mode_e;

  // ahb register byte addresses
  localparam logic [7:0] FHQ_ADDR_CONFIG = 8'h00;
  localparam logic [7:0] FHQ_ADDR_STATE = 8'h04;
  localparam logic [7:0] FHQ_ADDR_IRQ_STAT = 8'h08;
  localparam logic [7:0] FHQ_ADDR_IRQ_MASK = 8'h0C;

  // ahb encodings
  localparam logic [1:0] FHQ_HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] FHQ_HTRANS_SEQ = 2'h3;

  // operations register field positions (two latched bits)
  localparam int FHQ_OP_SEQ_ENABLE = 0;
  localparam int FHQ_OP_DMA_GATE = 1;
  localparam logic [1:0] FHQ_OP_RESET = 2'h0;

  // control register: rate code, the 300 kbs code selects the alternate clock
  localparam logic [1:0] FHQ_CTRL_RESET = 2'h0;
  localparam logic [1:0] FHQ_RATE_300K = 2'h1;

  // host data bus
  localparam int FHQ_DB_W = 8;
  localparam int FHQ_DB_MSB = 7;

  // interrupt status bits
  localparam int FHQ_IRQ_W = 4;
  localparam int FHQ_EV_TC = 0;
  localparam int FHQ_EV_ABORT = 1;
  localparam int FHQ_EV_SWAP = 2;
  localparam int FHQ_EV_FLUX_ERR = 3;
  localparam logic [3:0] FHQ_IRQ_MASK_RESET = 4'h0;

  // host-side pins, all taken as synchronous to clk
  typedef struct packed {
    logic csN;
    logic rdN;
    logic wrN;
    logic regSel;
    logic dackN;
    logic transferEnd;
    logic opLoadSelN;
    logic ctrlLoadSelN;
    logic swapGateN;
    logic swapN;
  } fhq_host_in_s;

  // signals from the microsequencer
  typedef struct packed {
    logic dmaCmd;
    logic byteReq;
    logic cmdDone;
    logic [7:0] dataByte;
    logic [7:0] statusByte;
  } fhq_seq_in_s;

endpackage : fhq_pkg

// ===== verilog/fhq_host_dma_qualify.sv
// host port glue: data bus, register load strobes, dma/irq/tc qualification
// assumes synchronous host pins, one clock, an ahb-lite master for config
//
// Functional notes
// - in dma commands transfer-end counts only with grant; base pio needs no grant
// - special or legacy mode: grant-qualified transfer-end needs the dma gating bit
// - legacy mode always needs grant on transfer-end, dma or not
// - legacy mode pio command completion reports an abnormal termination
// - 8-bit tristate data bus, line 0 is lsb, line 7 msb
// - dma request per byte; driven in base, else enabled by gating bit
// - irq on command completion and on pio byte requests
// - irq driven in base, else enabled by gating bit
// - media swap state on bit 7 of control read only while gate low
// - operations load select with write latches two lsbs into operations register
// - control load select with write latches two lsbs into control register
// - reset idles the sequencer, resets outputs, selects base mode
// - raw read stream falling edge marks one flux transition
// - alternate rate clock used only for 300 kbs, chosen by control register
// - grant acts as chip select with data select; gated outside base mode
//
// The AHB-Lite register port and the address map were chosen for this implementation.
`timescale 1ns/100ps

module fhq_host_dma_qualify
  import fhq_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  output logic irqOut,
  // host pins
  input wire fhq_host_in_s hostIn,
  input wire logic [7:0] hostDataIn,
  output logic [7:0] hostDataOut,
  output logic hostDataOe,
  output logic dmaReq,
  output logic dmaReqOe,
  output logic hostIrq,
  output logic hostIrqOe,
  // drive side
  input wire logic rawReadStream,
  // microsequencer side
  input wire fhq_seq_in_s seqIn,
  output logic seqIdle,
  output logic transferEndPulse,
  output logic abortPulse,
  output logic fluxPulse,
  output logic hostWrPulse,
  output logic [7:0] hostWrByte,
  output logic [1:0] opRegOut,
  output logic [1:0] ctrlRegOut,
  output logic altRateSel
);

  // state
  fhq_mode_e mode_reg, mode_next;
  logic [1:0] opReg_reg, opReg_next;
  logic [1:0] ctrlReg_reg, ctrlReg_next;
  logic [3:0] irqStat_reg, irqStat_next;
  logic [3:0] irqMask_reg, irqMask_next;
  logic cmdPend_reg, cmdPend_next;
  logic wrPrevN_reg, wrPrevN_next;
  logic rawPrev_reg, rawPrev_next;
  logic swapPrevN_reg, swapPrevN_next;
  logic dataPhWr_reg, dataPhWr_next;
  logic [7:0] dataPhAddr_reg, dataPhAddr_next;
  logic [31:0] hrdata_reg, hrdata_next;
  logic [7:0] dbOut_reg, dbOut_next;
  logic dbOe_reg, dbOe_next;
  logic dmaReq_reg, dmaReq_next;
  logic dmaOe_reg, dmaOe_next;
  logic hIrq_reg, hIrq_next;
  logic hIrqOe_reg, hIrqOe_next;
  logic teP_reg, teP_next;
  logic abP_reg, abP_next;
  logic flP_reg, flP_next;
  logic wrP_reg, wrP_next;
  logic [7:0] wrB_reg, wrB_next;
  logic irqOut_reg, irqOut_next;

  // decoded host conditions
  logic dmaGate;
  logic grantOk;
  logic dataSelect;
  logic hostRead;
  logic hostWrite;
  logic ctrlRead;
  logic teAccept;
  logic addrPhase;
  logic [3:0] events;

  // grant and select qualification, shared by several paths
  always_comb
  begin
    dmaGate = opReg_reg[FHQ_OP_DMA_GATE];
    // outside base mode the grant only counts with the gating bit set
    grantOk = !hostIn.dackN && (mode_reg == FHQ_MODE_BASE || dmaGate);
    dataSelect = (!hostIn.csN && hostIn.regSel) || grantOk;
    hostRead = !hostIn.rdN && (!hostIn.csN || grantOk);
    // status writes are illegal; they are simply dropped
    hostWrite = !hostIn.wrN && wrPrevN_reg && dataSelect;
    ctrlRead = !hostIn.rdN && !hostIn.ctrlLoadSelN;
    if (mode_reg == FHQ_MODE_LEGACY)
    begin
      teAccept = hostIn.transferEnd && grantOk;
    end
    else if (seqIn.dmaCmd)
    begin
      teAccept = hostIn.transferEnd && grantOk;
    end
    else
    begin
      teAccept = hostIn.transferEnd;
    end
    addrPhase = hsel && hready && (htrans == FHQ_HTRANS_NONSEQ || htrans == FHQ_HTRANS_SEQ);
    events = '0;
    events[FHQ_EV_TC] = teAccept;
    events[FHQ_EV_ABORT] = seqIn.cmdDone && !seqIn.dmaCmd && (mode_reg == FHQ_MODE_LEGACY);
    events[FHQ_EV_SWAP] = hostIn.swapN ^ swapPrevN_reg;
    events[FHQ_EV_FLUX_ERR] = 1'b0;
  end

  // next values for host-facing registers and pins
  always_comb
  begin
    opReg_next = opReg_reg;
    ctrlReg_next = ctrlReg_reg;
    // load select gated with write strobe latches the two lsbs
    if (!hostIn.opLoadSelN && !hostIn.wrN)
    begin
      opReg_next = hostDataIn[1:0];
    end
    if (!hostIn.ctrlLoadSelN && !hostIn.wrN)
    begin
      ctrlReg_next = hostDataIn[1:0];
    end
    wrPrevN_next = hostIn.wrN;
    rawPrev_next = rawReadStream;
    swapPrevN_next = hostIn.swapN;
    // falling edge of the raw stream is one flux transition
    flP_next = rawPrev_reg && !rawReadStream;
    teP_next = teAccept;
    abP_next = events[FHQ_EV_ABORT];
    wrP_next = hostWrite;
    wrB_next = hostWrite ? hostDataIn : wrB_reg;
    // completion stays pending until the host reads status
    cmdPend_next = cmdPend_reg;
    if (hostRead && !dataSelect)
    begin
      cmdPend_next = 1'b0;
    end
    if (seqIn.cmdDone)
    begin
      cmdPend_next = 1'b1; // set wins over the status-read clear
    end
    // data bus drive; bit order follows the port, bit 0 is the lsb
    dbOut_next = '0;
    dbOe_next = 1'b0;
    if (hostRead)
    begin
      dbOut_next = dataSelect ? seqIn.dataByte : seqIn.statusByte;
      dbOe_next = 1'b1;
    end
    else if (ctrlRead && !hostIn.swapGateN)
    begin
      dbOut_next[FHQ_DB_MSB] = hostIn.swapN;
      dbOe_next = 1'b1;
    end
    // dma request for every byte when the command runs in dma mode
    dmaReq_next = seqIn.dmaCmd && seqIn.byteReq;
    dmaOe_next = (mode_reg == FHQ_MODE_BASE) || dmaGate;
    hIrq_next = cmdPend_next || (!seqIn.dmaCmd && seqIn.byteReq);
    hIrqOe_next = (mode_reg == FHQ_MODE_BASE) || dmaGate;
  end

  // next values for the ahb slave and interrupt registers
  always_comb
  begin
    mode_next = mode_reg;
    irqMask_next = irqMask_reg;
    irqStat_next = irqStat_reg;
    dataPhWr_next = addrPhase && hwrite;
    dataPhAddr_next = addrPhase ? haddr : dataPhAddr_reg;
    hrdata_next = '0;
    // writes land in the data phase, when hwdata is valid
    if (dataPhWr_reg)
    begin
      if (dataPhAddr_reg == FHQ_ADDR_CONFIG)
      begin
        mode_next = fhq_mode_e'(hwdata[1:0]);
      end
      else if (dataPhAddr_reg == FHQ_ADDR_IRQ_MASK)
      begin
        irqMask_next = hwdata[FHQ_IRQ_W-1:0];
      end
    end
    // reads sample in the address phase so data stands in the data phase
    if (addrPhase && !hwrite)
    begin
      if (haddr == FHQ_ADDR_CONFIG)
      begin
        hrdata_next[1:0] = mode_reg;
      end
      else if (haddr == FHQ_ADDR_STATE)
      begin
        hrdata_next[5:0] = {altRateSel, cmdPend_reg, ctrlReg_reg, opReg_reg};
      end
      else if (haddr == FHQ_ADDR_IRQ_STAT)
      begin
        hrdata_next[FHQ_IRQ_W-1:0] = irqStat_reg;
        irqStat_next = '0;
      end
      else if (haddr == FHQ_ADDR_IRQ_MASK)
      begin
        hrdata_next[FHQ_IRQ_W-1:0] = irqMask_reg;
      end
      else
      begin
        hrdata_next = '0; // unmapped reads return zero
      end
    end
    // a new event beats the read clear in the same cycle
    irqStat_next = irqStat_next | events;
    irqOut_next = |(irqStat_next & irqMask_next);
  end

  // register stage; reset returns every output to its idle level
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      mode_reg <= FHQ_MODE_BASE;
      opReg_reg <= FHQ_OP_RESET;
      ctrlReg_reg <= FHQ_CTRL_RESET;
      irqStat_reg <= '0;
      irqMask_reg <= FHQ_IRQ_MASK_RESET;
      cmdPend_reg <= 1'b0;
      wrPrevN_reg <= 1'b1;
      rawPrev_reg <= 1'b1;
      swapPrevN_reg <= 1'b1;
      dataPhWr_reg <= 1'b0;
      dataPhAddr_reg <= '0;
      hrdata_reg <= '0;
      dbOut_reg <= '0;
      dbOe_reg <= 1'b0;
      dmaReq_reg <= 1'b0;
      dmaOe_reg <= 1'b1;
      hIrq_reg <= 1'b0;
      hIrqOe_reg <= 1'b1;
      teP_reg <= 1'b0;
      abP_reg <= 1'b0;
      flP_reg <= 1'b0;
      wrP_reg <= 1'b0;
      wrB_reg <= '0;
      irqOut_reg <= 1'b0;
      seqIdle <= 1'b1;
      altRateSel <= 1'b0;
    end
    else
    begin
      mode_reg <= mode_next;
      opReg_reg <= opReg_next;
      ctrlReg_reg <= ctrlReg_next;
      irqStat_reg <= irqStat_next;
      irqMask_reg <= irqMask_next;
      cmdPend_reg <= cmdPend_next;
      wrPrevN_reg <= wrPrevN_next;
      rawPrev_reg <= rawPrev_next;
      swapPrevN_reg <= swapPrevN_next;
      dataPhWr_reg <= dataPhWr_next;
      dataPhAddr_reg <= dataPhAddr_next;
      hrdata_reg <= hrdata_next;
      dbOut_reg <= dbOut_next;
      dbOe_reg <= dbOe_next;
      dmaReq_reg <= dmaReq_next;
      dmaOe_reg <= dmaOe_next;
      hIrq_reg <= hIrq_next;
      hIrqOe_reg <= hIrqOe_next;
      teP_reg <= teP_next;
      abP_reg <= abP_next;
      flP_reg <= flP_next;
      wrP_reg <= wrP_next;
      wrB_reg <= wrB_next;
      irqOut_reg <= irqOut_next;
      seqIdle <= 1'b0;
      // only the control register picks the alternate rate clock
      altRateSel <= (ctrlReg_reg == FHQ_RATE_300K);
    end
  end

  // outputs straight from flip-flops; zero wait state slave, always okay
  assign hrdata = hrdata_reg;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign irqOut = irqOut_reg;
  assign hostDataOut = dbOut_reg;
  assign hostDataOe = dbOe_reg;
  assign dmaReq = dmaReq_reg;
  assign dmaReqOe = dmaOe_reg;
  assign hostIrq = hIrq_reg;
  assign hostIrqOe = hIrqOe_reg;
  assign transferEndPulse = teP_reg;
  assign abortPulse = abP_reg;
  assign fluxPulse = flP_reg;
  assign hostWrPulse = wrP_reg;
  assign hostWrByte = wrB_reg;
  assign opRegOut = opReg_reg;
  assign ctrlRegOut = ctrlReg_reg;

endmodule : fhq_host_dma_qualify

// ===== test/fhq_host_dma_qualify_properties.sv
// checker for the host port block: pin, latch and pulse relations
// bound to the top module, sees only its ports
`timescale 1ns/100ps
module fhq_checker
  import fhq_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // host and sequencer side
  input wire fhq_host_in_s hostIn,
  input wire logic [7:0] hostDataIn,
  input wire logic [7:0] hostDataOut,
  input wire logic hostDataOe,
  input wire logic dmaReq,
  input wire logic dmaReqOe,
  input wire logic hostIrq,
  input wire logic hostIrqOe,
  input wire logic rawReadStream,
  input wire fhq_seq_in_s seqIn,
  input wire logic seqIdle,
  input wire logic transferEndPulse,
  input wire logic fluxPulse,
  input wire logic [1:0] opRegOut,
  input wire logic [1:0] ctrlRegOut,
  input wire logic altRateSel
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // load strobes: select low while write low
  sequence opLoad_q;
    !hostIn.opLoadSelN && !hostIn.wrN;
  endsequence
  sequence ctrlLoad_q;
    !hostIn.ctrlLoadSelN && !hostIn.wrN;
  endsequence
  chk_reset_idle: assert property (disable iff (1'b0)
    rst |=> seqIdle && dmaReqOe && hostIrqOe && !hostDataOe && !dmaReq && !hostIrq && !transferEndPulse)
    else $error("outputs off reset level");
  chk_op_latch: assert property (opLoad_q |=> opRegOut == $past(hostDataIn[1:0]))
    else $error("operations latch wrong");
  chk_ctrl_latch: assert property (ctrlLoad_q |=> ctrlRegOut == $past(hostDataIn[1:0]))
    else $error("control latch wrong");
  chk_alt_rate: assert property ($stable(ctrlRegOut) [*2] |-> altRateSel == (ctrlRegOut == FHQ_RATE_300K))
    else $error("alternate clock select wrong");
  chk_gate_drive: assert property
    (opRegOut[FHQ_OP_DMA_GATE] && $past(opRegOut[FHQ_OP_DMA_GATE]) |-> dmaReqOe && hostIrqOe)
    else $error("gated pins not driven");
  chk_dma_req: assert property (seqIn.dmaCmd && seqIn.byteReq |=> dmaReq)
    else $error("dma request missing");
  chk_pio_irq: assert property (!seqIn.dmaCmd && seqIn.byteReq |=> hostIrq)
    else $error("byte request irq missing");
  chk_done_irq: assert property (seqIn.cmdDone |=> hostIrq [*2])
    else $error("completion irq missing");
  chk_tc_grant: assert property (seqIn.dmaCmd && hostIn.dackN |=> !transferEndPulse)
    else $error("transfer end taken without grant");
  chk_swap_bit: assert property (!hostIn.ctrlLoadSelN && !hostIn.rdN && !hostIn.swapGateN
    && hostIn.csN && hostIn.dackN |=> hostDataOe && hostDataOut[FHQ_DB_MSB] == $past(hostIn.swapN))
    else $error("swap bit wrong");
  chk_bus_release: assert property ($past(hostIn.rdN) |-> !hostDataOe)
    else $error("bus driven without read");
  chk_flux_edge: assert property ($fell(rawReadStream) |=> fluxPulse)
    else $error("flux pulse missing");
endmodule : fhq_checker

// ===== test/fhq_host_model.sv
// host cpu and dma controller model driving the host pins
// assumes the block samples its pins on the rising edge of clk
`timescale 1ns/100ps
module fhq_host_model
  import fhq_pkg::*;
(
  // clock
  input wire logic clk,
  // pins toward the block
  output fhq_host_in_s hostIn,
  output logic [7:0] hostDataIn,
  // bus drive from the block
  input wire logic [7:0] hostDataOut,
  input wire logic hostDataOe
);
  // idle: strobes high, bus shows filler
  initial
  begin
    hostIn = 10'h3EF;
    hostDataIn = 8'hA5;
  end
  // one edge of load strobe, then the bus flips so stale data never matches
  task pinWrite(input logic ctrl, input logic [7:0] b);
    @(posedge clk);
    hostIn.regSel <= 1'b1;
    hostIn.wrN <= 1'b0;
    hostIn.opLoadSelN <= ctrl;
    hostIn.ctrlLoadSelN <= !ctrl;
    hostDataIn <= b;
    @(posedge clk);
    hostIn.wrN <= 1'b1;
    hostIn.opLoadSelN <= 1'b1;
    hostIn.ctrlLoadSelN <= 1'b1;
    hostDataIn <= ~b;
    @(posedge clk);
  endtask : pinWrite
  // control read, bus taken two edges in
  task ctrlRead(input logic gateN, output logic [7:0] b, output logic oe);
    @(posedge clk);
    hostIn.rdN <= 1'b0;
    hostIn.ctrlLoadSelN <= 1'b0;
    hostIn.swapGateN <= gateN;
    repeat (2) @(posedge clk);
    b = hostDataOut;
    oe = hostDataOe;
    hostIn.rdN <= 1'b1;
    hostIn.ctrlLoadSelN <= 1'b1;
  endtask : ctrlRead
  // one-cycle transfer end, with or without grant
  task endXfer(input logic grant);
    @(posedge clk);
    hostIn.dackN <= !grant;
    hostIn.transferEnd <= 1'b1;
    @(posedge clk);
    hostIn.dackN <= 1'b1;
    hostIn.transferEnd <= 1'b0;
  endtask : endXfer
  // cpu read through chip select; select high for data, low for status
  task hostRd(input logic sel, output logic [7:0] b, output logic oe);
    @(posedge clk);
    hostIn.csN <= 1'b0;
    hostIn.regSel <= sel;
    hostIn.rdN <= 1'b0;
    repeat (2) @(posedge clk);
    b = hostDataOut;
    oe = hostDataOe;
    hostIn.csN <= 1'b1;
    hostIn.regSel <= 1'b1;
    hostIn.rdN <= 1'b1;
  endtask : hostRd
  task setSwap(input logic v);
    @(posedge clk);
    hostIn.swapN <= v;
  endtask : setSwap
endmodule : fhq_host_model

// ===== test/fhq_host_dma_qualify_test.sv
// self-checking bench for the host port block
// drives ahb and sequencer pins; host pins come from the partner model
`timescale 1ns/100ps
module fhq_host_dma_qualify_test
  import fhq_pkg::*;
;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [7:0] haddr = 8'h00;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic rawReadStream = 1'b1;
  logic rawGo = 1'b0;
  logic hreadyout, hresp, irqOut, hostDataOe, dmaReq, dmaReqOe, hostIrq, hostIrqOe;
  logic seqIdle, transferEndPulse, fluxPulse, altRateSel, rawLast, oe;
  logic [7:0] hostDataIn, hostDataOut, b;
  logic [1:0] opRegOut, ctrlRegOut;
  logic [3:0] mask;
  logic [31:0] hrdata, rd, ex;
  fhq_host_in_s hostIn;
  fhq_seq_in_s seqIn = '0;
  int err_total = 0;
  int n_compared = 0;
  int seed = 32'hD921;
  int cycles = 0;
  int falls = 0;
  int pulses = 0;

  always #5 clk = ~clk;

  fhq_host_dma_qualify fhq_host_dma_qualify_i (.*, .hready(hreadyout), .abortPulse(), .hostWrPulse(), .hostWrByte());
  fhq_host_model fhq_host_model_i (.*);

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      $display("mismatch at %0t got %h expected %h", $time, got, exp);
      err_total++;
    end
  endtask : chk

  task stop_test();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : stop_test

  // single ahb word; waits on hready, no fixed latency assumed
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rdat);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= FHQ_HTRANS_NONSEQ;
    haddr <= a;
    hwrite <= wr;
    do @(posedge clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clk); while (hreadyout !== 1'b1);
    rdat = hrdata;
  endtask : ahb

  // status model: bit0 accepted transfer end, bit1 legacy pio abort
  function automatic logic [31:0] expStat(int m, int gate, int dma, int grant);
    int tc;
    tc = (m == 0) ? (dma ? grant : 1) : (m == 1) ? (dma ? grant & gate : 1) : (grant & gate);
    return {30'h0, (m == 2 && dma == 0), tc[0]};
  endfunction : expStat

  // random raw stream and byte requests; falls and flux pulses tallied, timeout
  always @(posedge clk)
  begin
    cycles++;
    rawReadStream <= rawGo ? 1'($random(seed)) : 1'b1;
    seqIn.byteReq <= rawGo & 1'($random(seed));
    if (!rst && rawLast && !rawReadStream)
      falls++;
    if (!rst && fluxPulse)
      pulses++;
    rawLast = rawReadStream;
    if (cycles == 5000)
    begin
      err_total++;
      stop_test();
    end
  end

  // main sequence: reset values, mode sweep, swap bit, flux count
  initial
  begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    ahb(1'b0, FHQ_ADDR_STATE, 32'h0, rd);
    chk(rd, 32'h0);
    chk({29'h0, dmaReqOe, hostIrqOe, hostDataOe}, 32'h6);
    ahb(1'b0, FHQ_ADDR_CONFIG, 32'h0, rd);
    chk(rd, 32'h0);
    ahb(1'b0, 8'h10, 32'h0, rd);
    chk(rd, 32'h0);
    rawGo <= 1'b1;
    for (int m = 0; m < 3; m++)
      for (int k = 0; k < 8; k++)
      begin
        b = 8'($random(seed));
        mask = 4'($random(seed));
        ahb(1'b1, FHQ_ADDR_CONFIG, m, rd);
        ahb(1'b1, FHQ_ADDR_IRQ_MASK, {28'h0, mask}, rd);
        fhq_host_model_i.pinWrite(1'b0, {b[7:2], k[0], b[0]});
        chk(opRegOut, {k[0], b[0]});
        fhq_host_model_i.pinWrite(1'b1, b);
        ahb(1'b0, FHQ_ADDR_STATE, 32'h0, rd);
        chk({rd[5], rd[3:0]}, {b[1:0] == FHQ_RATE_300K, b[1:0], k[0], b[0]});
        chk({dmaReqOe, hostIrqOe}, {2{m == 0 || k[0]}});
        seqIn.dmaCmd <= k[1];
        fhq_host_model_i.endXfer(k[2]);
        seqIn.cmdDone <= 1'b1;
        @(posedge clk);
        seqIn.cmdDone <= 1'b0;
        repeat (3) @(posedge clk);
        ex = expStat(m, k[0], k[1], k[2]);
        chk(irqOut, |(ex[3:0] & mask));
        ahb(1'b0, FHQ_ADDR_IRQ_STAT, 32'h0, rd);
        chk(rd, ex);
        ahb(1'b0, FHQ_ADDR_IRQ_STAT, 32'h0, rd);
        chk(rd, 32'h0);
        chk({31'h0, irqOut}, 32'h0);
      end
    for (int i = 0; i < 4; i++)
    begin
      b = 8'($random(seed));
      fhq_host_model_i.setSwap(b[0]);
      fhq_host_model_i.ctrlRead(i[0], rd[7:0], oe);
      chk({oe, oe & rd[7]}, {!i[0], !i[0] & b[0]});
    end
    rawGo <= 1'b0;
    repeat (4) @(posedge clk);
    chk(pulses, falls);
    // cpu data and status reads; the status read retires the pending completion
    ex = $random(seed);
    seqIn.dataByte <= ex[7:0];
    seqIn.statusByte <= ex[15:8];
    chk({31'h0, hostIrq}, 32'h1);
    fhq_host_model_i.hostRd(1'b1, rd[7:0], oe);
    chk({23'h0, oe, rd[7:0]}, {24'h1, ex[7:0]});
    fhq_host_model_i.hostRd(1'b0, rd[7:0], oe);
    chk({23'h0, oe, rd[7:0]}, {24'h1, ex[15:8]});
    chk({31'h0, hostIrq}, 32'h0);
    stop_test();
  end
endmodule : fhq_host_dma_qualify_test

bind fhq_host_dma_qualify fhq_checker fhq_checker_i (.*);
